// File: core/gfm_defs.vh
/*
 Constants shared by the pin function multiplexer and its per-pin decoder.
 Assumes an 8-bit register port and a byte-wide configuration memory port.

//Contract
//- Configuration loads from programmable memory at power-up.
//- Host programs each pin function over register port.
//- Bits 6:0 hold the pin function code.
//- Code 0x00 is plain input, no function.
//- Codes 0x10/0x14 flag reference 0/1 as failed.
//- Code 0x20 ORs with loop clear-enable bit.
//- Codes 0x44-0x47 OR into stop-clock bits.
//- Even codes 0x60-0x66 OR into differential enables.
//- Differential enable per output or whole group.
//- Codes 0x70/0x72 OR into CMOS output enables.
//- Status code 0x80 drives pin with interrupt.
//- Interrupt flags status change; host reads status.
//- Status 0x88 shows reference 0 inactivity.
//- Status 0x89 shows single period monitor failure.
//- Status 0x8A shows coarse frequency monitor failure.
*/
`ifndef GFM_DEFS_VH
`define GFM_DEFS_VH

`define GFM_NPIN 6
`define GFM_STAT_BIT 7
`define GFM_CODE_MSB 6
`define GFM_CFG_RST 8'h00

`define GFM_FN_LOSS0 7'h10
`define GFM_FN_LOSS1 7'h14
`define GFM_FN_CLR 7'h20
`define GFM_FN_STOP_CB1 7'h44
`define GFM_FN_STOP_CB0 7'h45
`define GFM_FN_STOP_DB1 7'h46
`define GFM_FN_STOP_DB0 7'h47
`define GFM_FN_DIFF0 7'h60
`define GFM_FN_DIFF1 7'h62
`define GFM_FN_DIFF2 7'h64
`define GFM_FN_DIFF3 7'h66
`define GFM_FN_CMOS0 7'h70
`define GFM_FN_CMOS1 7'h72
`define GFM_ST_IRQ 7'h00
`define GFM_ST_NOACT 7'h08
`define GFM_ST_SCM 7'h09
`define GFM_ST_CFM 7'h0a

`define GFM_FX_LOSS0 0
`define GFM_FX_LOSS1 1
`define GFM_FX_CLR 2
`define GFM_FX_STOP 3
`define GFM_FX_DIFF 7
`define GFM_FX_CMOS 11
`define GFM_NFX 13

`define GFM_A_LOOP 8'h06
`define GFM_A_STOP 8'h07
`define GFM_A_DIFF 8'h08
`define GFM_A_CMOS 8'h09
`define GFM_A_GROUP 8'h0a
`define GFM_A_MASK 8'h0b
`define GFM_A_STAT 8'h10
`define GFM_A_PINS 8'h11
`define GFM_A_REF 8'h12
`define GFM_A_LOAD 8'h13
`define GFM_OTP_LAST 8'h0b
`define GFM_OTP_FIRST 8'h00

`define GFM_NSTOP 4
`define GFM_NDIFF 4
`define GFM_NCMOS 2
`define GFM_NIRQ 5
`define GFM_IRQ_FAIL0 0
`define GFM_IRQ_FAIL1 1
`define GFM_IRQ_OK0 2
`define GFM_IRQ_OK1 3
`define GFM_IRQ_LOADED 4
`define GFM_LOOP_CLR_BIT 0
`define GFM_GROUP_DIFF_BIT 0

`endif

// File: core/gfm_pin_slice.v
/*
 Per-pin function decoder: turns one configuration byte into control hits
 or a status drive. Purely combinational; the top registers every result.
*/
`timescale 1ns/1ps
`include "gfm_defs.vh"

module gfm_pin_slice (
	input wire [7:0] cfg, // Pin configuration byte
	input wire pin_in, // Pin level as sampled
	input wire irq, // Device interrupt level
	input wire ref0_noact, // Reference 0 idle last second
	input wire ref0_scm, // Reference 0 period monitor fail
	input wire ref0_cfm, // Reference 0 frequency monitor fail
	output reg [`GFM_NFX-1:0] fn_hit, // Control functions asserted by pin
	output reg drv_out, // Level to drive
	output reg drv_oe // Pin is driven
);

wire is_stat;
wire [`GFM_CODE_MSB:0] code;

assign is_stat = cfg[`GFM_STAT_BIT];
assign code = cfg[`GFM_CODE_MSB:0];

always @* begin
	fn_hit = {`GFM_NFX{1'b0}};
	drv_out = 1'b0;
	drv_oe = 1'b0;
	if (!is_stat) begin
		case (code)
		`GFM_FN_LOSS0: fn_hit[`GFM_FX_LOSS0] = pin_in;
		`GFM_FN_LOSS1: fn_hit[`GFM_FX_LOSS1] = pin_in;
		`GFM_FN_CLR: fn_hit[`GFM_FX_CLR] = pin_in;
		`GFM_FN_STOP_CB1: fn_hit[`GFM_FX_STOP + 3] = pin_in;
		`GFM_FN_STOP_CB0: fn_hit[`GFM_FX_STOP + 2] = pin_in;
		`GFM_FN_STOP_DB1: fn_hit[`GFM_FX_STOP + 1] = pin_in;
		`GFM_FN_STOP_DB0: fn_hit[`GFM_FX_STOP] = pin_in;
		`GFM_FN_DIFF0: fn_hit[`GFM_FX_DIFF] = pin_in;
		`GFM_FN_DIFF1: fn_hit[`GFM_FX_DIFF + 1] = pin_in;
		`GFM_FN_DIFF2: fn_hit[`GFM_FX_DIFF + 2] = pin_in;
		`GFM_FN_DIFF3: fn_hit[`GFM_FX_DIFF + 3] = pin_in;
		`GFM_FN_CMOS0: fn_hit[`GFM_FX_CMOS] = pin_in;
		`GFM_FN_CMOS1: fn_hit[`GFM_FX_CMOS + 1] = pin_in;
		default: fn_hit = {`GFM_NFX{1'b0}};
		endcase
	end else begin
		case (code)
		`GFM_ST_IRQ: begin
			drv_oe = 1'b1;
			drv_out = irq;
		end
		`GFM_ST_NOACT: begin
			drv_oe = 1'b1;
			drv_out = ref0_noact;
		end
		`GFM_ST_SCM: begin
			drv_oe = 1'b1;
			drv_out = ref0_scm;
		end
		`GFM_ST_CFM: begin
			drv_oe = 1'b1;
			drv_out = ref0_cfm;
		end
		default: drv_oe = 1'b0;
		endcase
	end
end

endmodule

// File: core/gfm_gpio_mux.v
/*
 General-purpose pin function multiplexer with its register file, the
 power-up load from configuration memory and the status interrupt.
 Assumes pin inputs and monitor flags are already synchronous to clk, and a
 memory that returns the addressed byte one cycle after its read strobe.
*/
`timescale 1ns/1ps
`include "gfm_defs.vh"

module gfm_gpio_mux (
	input wire clk, // System clock, 10 MHz
	input wire reset_n, // Synchronous reset, active low
	input wire [7:0] bus_addr, // Register address
	input wire [7:0] bus_wdata, // Register write data
	input wire bus_wr, // Write strobe
	input wire bus_rd, // Read strobe
	output wire [7:0] bus_rdata, // Read data, cycle after strobe
	output wire otp_rd, // Configuration memory read strobe
	output wire [7:0] otp_addr, // Configuration memory address
	input wire [7:0] otp_rdata, // Memory byte, cycle after strobe
	input wire [`GFM_NPIN-1:0] gpio_in, // Pin input levels
	output wire [`GFM_NPIN-1:0] gpio_out, // Pin output levels
	output wire [`GFM_NPIN-1:0] gpio_oe, // Pin output enables
	input wire [1:0] ref_mon_fail, // Internal reference monitor fails
	input wire ref0_noact, // Reference 0 idle in last second
	input wire ref0_scm_fail, // Reference 0 single period monitor
	input wire ref0_cfm_fail, // Reference 0 coarse freq monitor
	output wire [1:0] ref_failed, // References treated as failed
	output wire tie_clr_en, // Effective phase error clear enable
	output wire [`GFM_NSTOP-1:0] stop_clk, // Post divider C/D stop bits
	output wire [`GFM_NDIFF-1:0] diff_en, // Differential output enables
	output wire [`GFM_NCMOS-1:0] cmos_en, // CMOS output enables
	output wire irq, // Interrupt, active high level
	output wire cfg_loaded // Power-up load finished
);

localparam [2:0] S_ISSUE = 3'b001;
localparam [2:0] S_WAIT = 3'b010;
localparam [2:0] S_RUN = 3'b100;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [7:0] otp_addr_r;
reg [7:0] otp_addr_nxt;
reg otp_rd_r;
reg otp_rd_nxt;

reg [7:0] cfg_r [0:`GFM_NPIN-1];
reg loop_clr_r;
reg [`GFM_NSTOP-1:0] stop_reg_r;
reg [`GFM_NDIFF-1:0] diff_reg_r;
reg [`GFM_NCMOS-1:0] cmos_reg_r;
reg group_r;
reg [`GFM_NIRQ-1:0] mask_r;
reg [`GFM_NIRQ-1:0] stat_r;
reg [`GFM_NIRQ-1:0] stat_nxt;

reg [1:0] ref_fail_r;
reg tie_clr_r;
reg [`GFM_NSTOP-1:0] stop_r;
reg [`GFM_NDIFF-1:0] diff_r;
reg [`GFM_NCMOS-1:0] cmos_r;
reg irq_r;
reg [`GFM_NPIN-1:0] gpio_out_r;
reg [`GFM_NPIN-1:0] gpio_oe_r;
reg [7:0] rdata_r;
reg [7:0] rd_mux;
// Capture stage of the memory read and the loaded flag
reg cap_r;
reg [7:0] cap_addr_r;
reg loaded_r;
reg loaded_nxt;

wire [`GFM_NFX-1:0] hit [0:`GFM_NPIN-1];
wire [`GFM_NPIN-1:0] drv_out;
wire [`GFM_NPIN-1:0] drv_oe;
reg [`GFM_NFX-1:0] hit_any;
wire loading;
wire load_we;
wire wr_we;
wire [7:0] wr_addr;
wire [7:0] wr_data;
wire [1:0] ref_fail_nxt;
wire diff_any;
wire [`GFM_NDIFF-1:0] diff_nxt;
wire stat_rd;
integer i;
integer j;
integer k;

// The memory answers one cycle after its strobe, so the byte is written
// in the cycle after the strobe, with the address that went out beside it
assign load_we = cap_r;
assign loading = ~loaded_r;

// Host writes are dropped while the memory image loads, so the image wins
assign wr_we = load_we | (bus_wr & ~loading);
assign wr_addr = load_we ? cap_addr_r : bus_addr;
assign wr_data = load_we ? otp_rdata : bus_wdata;

// Power-up load walks the image one byte per two cycles
// The strobe stands during the wait state; the image has no gaps, so the
// walk simply stops at the last address
always @* begin
	state_nxt = state_r;
	otp_addr_nxt = otp_addr_r;
	otp_rd_nxt = 1'b0;
	case (state_r)
	S_ISSUE: begin
		otp_rd_nxt = 1'b1;
		state_nxt = S_WAIT;
	end
	S_WAIT: begin
		if (otp_addr_r == `GFM_OTP_LAST) begin
			state_nxt = S_RUN;
		end else begin
			otp_addr_nxt = otp_addr_r + 8'h01;
			state_nxt = S_ISSUE;
		end
	end
	S_RUN: begin
		state_nxt = S_RUN;
	end
	default: begin
		state_nxt = S_ISSUE;
		otp_addr_nxt = `GFM_OTP_FIRST;
	end
	endcase
end

always @(posedge clk) begin
	if (!reset_n) begin
		state_r <= S_ISSUE;
		otp_addr_r <= `GFM_OTP_FIRST;
		otp_rd_r <= 1'b0;
	end else begin
		state_r <= state_nxt;
		otp_addr_r <= otp_addr_nxt;
		otp_rd_r <= otp_rd_nxt;
	end
end

// Capture stage: remembers which strobe is answered in this cycle
always @(posedge clk) begin
	if (!reset_n) begin
		cap_r <= 1'b0;
		cap_addr_r <= `GFM_OTP_FIRST;
	end else begin
		cap_r <= otp_rd_r;
		cap_addr_r <= otp_addr_r;
	end
end

// Loaded flag rises on the same edge that writes the last image byte and then holds
always @* begin
	loaded_nxt = loaded_r;
	if (cap_r & (cap_addr_r == `GFM_OTP_LAST)) begin
		loaded_nxt = 1'b1;
	end
end

always @(posedge clk) begin
	if (!reset_n) begin
		loaded_r <= 1'b0;
	end else begin
		loaded_r <= loaded_nxt;
	end
end

// Writable registers share one write port for load and host
always @(posedge clk) begin
	if (!reset_n) begin
		for (i = 0; i < `GFM_NPIN; i = i + 1) begin
			cfg_r[i] <= `GFM_CFG_RST;
		end
		loop_clr_r <= 1'b0;
		stop_reg_r <= {`GFM_NSTOP{1'b0}};
		diff_reg_r <= {`GFM_NDIFF{1'b0}};
		cmos_reg_r <= {`GFM_NCMOS{1'b0}};
		group_r <= 1'b0;
		mask_r <= {`GFM_NIRQ{1'b0}};
	end else if (wr_we) begin
		for (i = 0; i < `GFM_NPIN; i = i + 1) begin
			if (wr_addr == i[7:0]) begin
				cfg_r[i] <= wr_data;
			end
		end
		case (wr_addr)
		`GFM_A_LOOP: loop_clr_r <= wr_data[`GFM_LOOP_CLR_BIT];
		`GFM_A_STOP: stop_reg_r <= wr_data[`GFM_NSTOP-1:0];
		`GFM_A_DIFF: diff_reg_r <= wr_data[`GFM_NDIFF-1:0];
		`GFM_A_CMOS: cmos_reg_r <= wr_data[`GFM_NCMOS-1:0];
		`GFM_A_GROUP: group_r <= wr_data[`GFM_GROUP_DIFF_BIT];
		`GFM_A_MASK: mask_r <= wr_data[`GFM_NIRQ-1:0];
		default: group_r <= group_r;
		endcase
	end
end

// One decoder per pin; each sees the registered interrupt, so a status
// pin shows the interrupt one cycle after the irq output
genvar g;
generate
	for (g = 0; g < `GFM_NPIN; g = g + 1) begin : pin
		gfm_pin_slice u_slice (
			.cfg(cfg_r[g]),
			.pin_in(gpio_in[g]),
			.irq(irq_r),
			.ref0_noact(ref0_noact),
			.ref0_scm(ref0_scm_fail),
			.ref0_cfm(ref0_cfm_fail),
			.fn_hit(hit[g]),
			.drv_out(drv_out[g]),
			.drv_oe(drv_oe[g])
		);
	end
endgenerate

// Several pins may carry the same function; any of them asserts it
always @* begin
	hit_any = {`GFM_NFX{1'b0}};
	for (j = 0; j < `GFM_NPIN; j = j + 1) begin
		hit_any = hit_any | hit[j];
	end
end

// An external loss indication and the internal monitor are ORed, so
// either one alone marks the reference as failed
assign ref_fail_nxt[0] = hit_any[`GFM_FX_LOSS0] | ref_mon_fail[0];
assign ref_fail_nxt[1] = hit_any[`GFM_FX_LOSS1] | ref_mon_fail[1];

// Group mode lets any one enable request switch on the whole bank
assign diff_any = |(hit_any[`GFM_FX_DIFF+`GFM_NDIFF-1:`GFM_FX_DIFF] | diff_reg_r);
assign diff_nxt = group_r ? {`GFM_NDIFF{diff_any}} :
	(hit_any[`GFM_FX_DIFF+`GFM_NDIFF-1:`GFM_FX_DIFF] | diff_reg_r);

// Control outputs: pin request ORed with the register bit (with the internal monitor for ref_failed), one cycle
// after the pin level is sampled
always @(posedge clk) begin
	if (!reset_n) begin
		ref_fail_r <= 2'b00;
		tie_clr_r <= 1'b0;
		stop_r <= {`GFM_NSTOP{1'b0}};
		diff_r <= {`GFM_NDIFF{1'b0}};
		cmos_r <= {`GFM_NCMOS{1'b0}};
		gpio_out_r <= {`GFM_NPIN{1'b0}};
		gpio_oe_r <= {`GFM_NPIN{1'b0}};
	end else begin
		ref_fail_r <= ref_fail_nxt;
		tie_clr_r <= hit_any[`GFM_FX_CLR] | loop_clr_r;
		stop_r <= hit_any[`GFM_FX_STOP+`GFM_NSTOP-1:`GFM_FX_STOP] | stop_reg_r;
		diff_r <= diff_nxt;
		cmos_r <= hit_any[`GFM_FX_CMOS+`GFM_NCMOS-1:`GFM_FX_CMOS] | cmos_reg_r;
		gpio_out_r <= drv_out;
		gpio_oe_r <= drv_oe;
	end
end

// Status bits record changes; a set in the clearing cycle survives
// Only transitions are recorded; a reference that stays failed raises one event
assign stat_rd = bus_rd & (bus_addr == `GFM_A_STAT);

always @* begin
	stat_nxt = stat_r;
	if (stat_rd) begin
		stat_nxt = {`GFM_NIRQ{1'b0}};
	end
	if (ref_fail_nxt[0] & ~ref_fail_r[0]) begin
		stat_nxt[`GFM_IRQ_FAIL0] = 1'b1;
	end
	if (ref_fail_nxt[1] & ~ref_fail_r[1]) begin
		stat_nxt[`GFM_IRQ_FAIL1] = 1'b1;
	end
	if (~ref_fail_nxt[0] & ref_fail_r[0]) begin
		stat_nxt[`GFM_IRQ_OK0] = 1'b1;
	end
	if (~ref_fail_nxt[1] & ref_fail_r[1]) begin
		stat_nxt[`GFM_IRQ_OK1] = 1'b1;
	end
	if (loaded_nxt & ~loaded_r) begin
		stat_nxt[`GFM_IRQ_LOADED] = 1'b1;
	end
end

always @(posedge clk) begin
	if (!reset_n) begin
		stat_r <= {`GFM_NIRQ{1'b0}};
		irq_r <= 1'b0;
	end else begin
		stat_r <= stat_nxt;
		irq_r <= |(stat_nxt & mask_r);
	end
end

// Read mux; a pending status set is reported on the next read
always @* begin
	rd_mux = 8'h00;
	case (bus_addr)
	`GFM_A_LOOP: rd_mux[`GFM_LOOP_CLR_BIT] = loop_clr_r;
	`GFM_A_STOP: rd_mux[`GFM_NSTOP-1:0] = stop_reg_r;
	`GFM_A_DIFF: rd_mux[`GFM_NDIFF-1:0] = diff_reg_r;
	`GFM_A_CMOS: rd_mux[`GFM_NCMOS-1:0] = cmos_reg_r;
	`GFM_A_GROUP: rd_mux[`GFM_GROUP_DIFF_BIT] = group_r;
	`GFM_A_MASK: rd_mux[`GFM_NIRQ-1:0] = mask_r;
	`GFM_A_STAT: rd_mux[`GFM_NIRQ-1:0] = stat_r;
	`GFM_A_PINS: rd_mux[`GFM_NPIN-1:0] = gpio_in;
	`GFM_A_REF: rd_mux[1:0] = ref_fail_r;
	`GFM_A_LOAD: rd_mux[0] = ~loading;
	default: begin
		for (k = 0; k < `GFM_NPIN; k = k + 1) begin
			if (bus_addr == k[7:0]) begin
				rd_mux = cfg_r[k];
			end
		end
	end
	endcase
end

// Read data stands for the answer cycle only and is zero otherwise, so a
// stale value never looks like a fresh answer
always @(posedge clk) begin
	if (!reset_n) begin
		rdata_r <= 8'h00;
	end else if (bus_rd) begin
		rdata_r <= rd_mux;
	end else begin
		rdata_r <= 8'h00;
	end
end

// Every output below comes straight from a register
assign bus_rdata = rdata_r;
assign otp_rd = otp_rd_r;
assign otp_addr = otp_addr_r;
assign gpio_out = gpio_out_r;
assign gpio_oe = gpio_oe_r;
assign ref_failed = ref_fail_r;
assign tie_clr_en = tie_clr_r;
assign stop_clk = stop_r;
assign diff_en = diff_r;
assign cmos_en = cmos_r;
assign irq = irq_r;
assign cfg_loaded = loaded_r;

endmodule

// File: verification/gfm_otp_model.sv
/*
 Configuration memory model holding the power-up image of registers 0x00..0x0b.
 Assumes the mux strobes otp_rd for one cycle and samples data the cycle after.
*/
`timescale 1ns/1ps

module gfm_otp_model (
	input wire clk, // System clock
	input wire otp_rd, // Read strobe
	input wire [7:0] otp_addr, // Byte address
	output reg [7:0] otp_rdata // Byte, valid only the cycle after the strobe
);
	reg [7:0] mem [0:11];
	initial begin
		otp_rdata = 8'h5a;
		mem[0] = 8'h60;
		mem[1] = 8'h10;
		mem[2] = 8'h80;
		mem[3] = 8'h88;
		mem[4] = 8'h44;
		mem[5] = 8'h7f;
		mem[6] = 8'h00;
		mem[7] = 8'h00;
		mem[8] = 8'h00;
		mem[9] = 8'h00;
		mem[10] = 8'h00;
		mem[11] = 8'h1f;
	end
	// Stale data is inverted so a late sample cannot pass by luck
	always @(posedge clk) begin
		if (otp_rd)
			otp_rdata <= (otp_addr < 8'h0c) ? mem[otp_addr] : 8'hc3;
		else
			otp_rdata <= ~otp_rdata;
	end
endmodule

// File: verification/gfm_mux_assertions.sv
/*
 Port-level checker for the pin function mux: register port, load, interrupt.
 Assumes it is bound to the mux top and sees only its ports.
*/
`timescale 1ns/1ps

module gfm_mux_assertions (
	input wire clk, // System clock
	input wire reset_n, // Synchronous reset, active low
	input wire [7:0] bus_addr, // Register address
	input wire [7:0] bus_wdata, // Write data
	input wire bus_wr, // Write strobe
	input wire bus_rd, // Read strobe
	input wire [7:0] bus_rdata, // Read data
	input wire otp_rd, // Memory strobe
	input wire [7:0] otp_addr, // Memory address
	input wire [5:0] gpio_in, // Pin levels
	input wire [1:0] ref_mon_fail, // Internal monitor fails
	input wire [1:0] ref_failed, // References treated as failed
	input wire irq, // Interrupt level
	input wire cfg_loaded // Load finished
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_last_fetch;
		otp_rd && otp_addr == 8'h0b;
	endsequence
	sequence s_mask_off;
		bus_wr && cfg_loaded && bus_addr == 8'h0b && bus_wdata == 8'h00;
	endsequence

	property p_rdata_idle;
		!$past(bus_rd) |-> bus_rdata == 8'h00;
	endproperty
	property p_pin_read;
		bus_rd && bus_addr == 8'h11 |=> bus_rdata == {2'b00, $past(gpio_in)};
	endproperty
	property p_unmapped;
		bus_rd && bus_addr > 8'h13 |=> bus_rdata == 8'h00;
	endproperty
	property p_loss_or;
		$past(reset_n) |-> (ref_failed & $past(ref_mon_fail)) == $past(ref_mon_fail);
	endproperty
	property p_load_start;
		$rose(reset_n) |-> ##[0:2] (otp_rd && otp_addr == 8'h00);
	endproperty
	property p_otp_pulse;
		otp_rd |=> !otp_rd;
	endproperty
	property p_otp_range;
		otp_rd |-> otp_addr <= 8'h0b;
	endproperty
	property p_load_done;
		s_last_fetch |-> ##[1:3] cfg_loaded;
	endproperty
	property p_loaded_hold;
		cfg_loaded |=> cfg_loaded;
	endproperty
	property p_irq_mask;
		s_mask_off |=> ##1 !irq;
	endproperty

	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	a_pin_read: assert property (p_pin_read) else $error("pin level readback wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_loss_or: assert property (p_loss_or) else $error("monitor fail not ORed");
	a_load_start: assert property (p_load_start) else $error("load did not start");
	a_otp_pulse: assert property (p_otp_pulse) else $error("memory strobe too long");
	a_otp_range: assert property (p_otp_range) else $error("memory address out of image");
	a_load_done: assert property (p_load_done) else $error("load never finished");
	a_loaded_hold: assert property (p_loaded_hold) else $error("loaded flag dropped");
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
endmodule

// File: verification/testbench.sv
/*
 Self-checking bench for the pin function mux: load, register port, pin table.
 Assumes the configuration memory model drives the power-up image.
*/
`timescale 1ns/1ps

module testbench;
	reg clk = 0, reset_n = 0, bus_wr = 0, bus_rd = 0;
	reg [7:0] bus_addr = 0, bus_wdata = 0, d;
	reg [5:0] gpio_in = 0;
	reg [1:0] ref_mon_fail = 0;
	reg ref0_noact = 0, ref0_scm_fail = 0, ref0_cfm_fail = 0;
	wire [7:0] bus_rdata, otp_addr, otp_rdata;
	wire otp_rd, irq, cfg_loaded, tie_clr_en;
	wire [5:0] gpio_out, gpio_oe;
	wire [1:0] ref_failed, cmos_en;
	wire [3:0] stop_clk, diff_en;
	wire [12:0] ctl = {ref_failed, tie_clr_en, stop_clk, diff_en, cmos_en};
	integer error_cnt = 0, tests_run = 0, i;
	// Control codes and the output each must raise, unassigned ones last
	localparam [127:0] CODES = {8'h00, 8'h10, 8'h14, 8'h20, 8'h44, 8'h45, 8'h46, 8'h47,
		8'h60, 8'h62, 8'h64, 8'h66, 8'h70, 8'h72, 8'h7f, 8'h11};
	localparam [207:0] EXPV = {13'h0, 13'h800, 13'h1000, 13'h400, 13'h200, 13'h100, 13'h80,
		13'h40, 13'h4, 13'h8, 13'h10, 13'h20, 13'h1, 13'h2, 13'h0, 13'h0};

	always #50 clk = ~clk;

	gfm_gpio_mux DUT (.clk, .reset_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.otp_rd, .otp_addr, .otp_rdata, .gpio_in, .gpio_out, .gpio_oe, .ref_mon_fail,
		.ref0_noact, .ref0_scm_fail, .ref0_cfm_fail, .ref_failed, .tie_clr_en, .stop_clk,
		.diff_en, .cmos_en, .irq, .cfg_loaded);
	gfm_otp_model u_otp (.clk, .otp_rd, .otp_addr, .otp_rdata);

	task chk(input [13:0] got, input [13:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge clk) {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, v};
			@(posedge clk) bus_wr <= 0;
		end
	endtask
	task rd(input [7:0] a, output [7:0] v);
		begin
			@(posedge clk) {bus_rd, bus_addr} <= {1'b1, a};
			@(posedge clk) bus_rd <= 0;
			#1 v = bus_rdata;
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task wrap_up;
		begin
			$display("errors %0d checks %0d", error_cnt, tests_run);
			if (error_cnt == 0 && tests_run > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// Whole run is a few hundred cycles
	initial begin
		#(5000 * 100);
		error_cnt = error_cnt + 1;
		wrap_up;
	end

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1;
		for (i = 0; i < 40 && cfg_loaded !== 1'b1; i = i + 1)
			tick(1);
		chk(cfg_loaded, 1);
		for (i = 0; i < 12; i = i + 1) begin
			rd(i[7:0], d);
			chk(d, u_otp.mem[i]);
		end
		chk({irq, gpio_out[2], gpio_oe[2]}, 3'b111);
		rd(8'h10, d);
		chk(d, 8'h10);
		tick(3);
		chk({irq, gpio_out[2], gpio_oe[2]}, 3'b001);
		rd(8'h3f, d);
		chk(d, 8'h00);
		for (i = 0; i < 16; i = i + 1) begin
			wr(8'h00, CODES[8 * (15 - i) +: 8]);
			@(posedge clk) gpio_in <= 6'h01;
			tick(2);
			chk({gpio_oe[0], ctl}, EXPV[13 * (15 - i) +: 13]);
			@(posedge clk) gpio_in <= 6'h00;
			tick(2);
			chk(ctl, 13'h0);
		end
		wr(8'h00, 8'h60);
		@(posedge clk) gpio_in <= 6'h01;
		wr(8'h08, 8'h02);
		tick(2);
		chk(diff_en, 4'h3);
		wr(8'h0a, 8'h01);
		tick(2);
		chk(diff_en, 4'hf);
		@(posedge clk) gpio_in <= 6'h00;
		wr(8'h08, 8'h00);
		tick(2);
		chk(diff_en, 4'h0);
		wr(8'h0a, 8'h00);
		wr(8'h06, 8'h01);
		wr(8'h07, 8'h05);
		wr(8'h09, 8'h02);
		tick(2);
		chk(ctl, 13'h0542);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'h00);
		wr(8'h09, 8'h00);
		for (i = 0; i < 3; i = i + 1) begin
			wr(8'h03, 8'h88 + i[7:0]);
			@(posedge clk) {ref0_noact, ref0_scm_fail, ref0_cfm_fail} <= 3'b100 >> i;
			tick(2);
			chk({gpio_oe[3], gpio_out[3]}, 2'b11);
			@(posedge clk) {ref0_noact, ref0_scm_fail, ref0_cfm_fail} <= 3'b000;
			tick(2);
			chk({gpio_oe[3], gpio_out[3]}, 2'b10);
		end
		wr(8'h03, 8'h8f);
		@(posedge clk) ref0_noact <= 1;
		tick(2);
		chk(gpio_oe[3], 0);
		rd(8'h10, d);
		tick(2);
		chk(irq, 0);
		@(posedge clk) gpio_in <= 6'h02;
		tick(3);
		chk({ref_failed, irq}, 3'b011);
		rd(8'h11, d);
		chk(d, 8'h02);
		rd(8'h10, d);
		chk(d, 8'h01);
		wr(8'h0b, 8'h00);
		@(posedge clk) gpio_in <= 6'h00;
		tick(3);
		chk(irq, 0);
		rd(8'h10, d);
		chk(d, 8'h04);
		@(posedge clk) ref_mon_fail <= 2'b10;
		tick(2);
		chk(ref_failed, 2'b10);
		wrap_up;
	end
endmodule

bind gfm_gpio_mux gfm_mux_assertions u_chk (.clk, .reset_n, .bus_addr, .bus_wdata, .bus_wr,
	.bus_rd, .bus_rdata, .otp_rd, .otp_addr, .gpio_in, .ref_mon_fail, .ref_failed, .irq,
	.cfg_loaded);
